// ---- src/jtxsl_pkg.sv ----
// shared constants and types for the transmit link timing block
package jtxsl_pkg;
   // ************************************************************
   // sample and lane formats
   // ************************************************************
   localparam int SAMPLE_W = 14;
   localparam int FIFO_DEPTH = 4;
   localparam int FRAMES_PER_MF = 32;
   localparam int LAS_MF = 4;
   localparam int DLY_DEPTH = 28;
   localparam logic [7:0] K28_5 = 8'hBC;
   localparam logic [7:0] K28_0 = 8'h1C;
   localparam logic [7:0] K28_3 = 8'h7C;
   // ************************************************************
   // latencies in half sampling periods and sampling periods
   // ************************************************************
   localparam int LAT_P1_HALF = 21;
   localparam int LAT_P2_HALF = 27;
   localparam logic [3:0] LAT_SC1 = 4'h7;
   localparam logic [3:0] LAT_SC2 = 4'hA;
   localparam logic [3:0] LAT_SL1 = 4'h3;
   localparam logic [3:0] LAT_SL2 = 4'h6;
   localparam real OUT_DELAY_MAX_TS = 0.6;
   // ************************************************************
   // lane bit period limits in ps (set by the serialiser clocking) and system clock period in ns
   // ************************************************************
   localparam int BIT_PS_MIN_1L = 167;
   localparam int BIT_PS_MIN_2L = 294;
   localparam int BIT_PS_MAX = 1000;
   localparam int CLK_NS = 25;
   typedef struct packed {
      logic [SAMPLE_W-1:0] chanA;
      logic [SAMPLE_W-1:0] chanB;
   } jtxsl_sample_t;
   typedef struct packed {
      logic        isCtrl;
      logic [31:0] word;
   } jtxsl_lane_t;
   typedef enum logic [2:0] {
      ST_DATA, ST_COMMA_WAIT, ST_COMMA, ST_BOUND, ST_LAS_WAIT, ST_LAS
   } jtxsl_state_t;
endpackage

// ---- src/jtxsl_top.sv ----
// transmit link timing: sample pipeline, comma and alignment sequencing
//
// Overview of operation
// [RULE1] one lane: pipeline latency 10.5 sampling periods
// [RULE2] two lanes: pipeline latency 13.5 sampling periods
// [RULE3] commas start 7 or 10 periods after request
// [RULE4] alignment sequence 3 or 6 periods after release
// [RULE5] subclass 0 counts from next frame start
// [RULE6] subclass 1/2 count from next multiframe start
// [RULE7] clock edge to lane data within 0.6 periods
// [RULE8] lane bit period within mode limits
// [RULE9] halve select doubles clock versus sample rate
// [RULE10] sync low keeps commas on lanes
// [RULE11] sysref or sync rise resets dividers
// [RULE12] halved clock samples every second edge
// [RULE13] one lane carries both channels; else split
// [RULE14] data flows after alignment until next request
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// sample fifo
// ****************************************************************
module jtxsl_fifo #(
   parameter int WIDTH = 28,
   parameter int DEPTH = 4
) (
   input  wire logic             clk_sys,
   input  wire logic             nrst,
   input  wire logic [WIDTH-1:0] inData,
   input  wire logic             inValid,
   output logic                  inReady,
   output logic      [WIDTH-1:0] outData,
   output logic                  outValid,
   input  wire logic             outReady
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW:0]      wr_reg, wr_next, rd_reg, rd_next;
   logic             push, pop;
   // pointer update with extra wrap bit for full/empty
   always_comb begin
      inReady  = (wr_reg - rd_reg) != (AW+1)'(DEPTH);
      outValid = wr_reg != rd_reg;
      push     = inValid && inReady;
      pop      = outValid && outReady;
      wr_next  = push ? wr_reg + 1'b1 : wr_reg;
      rd_next  = pop ? rd_reg + 1'b1 : rd_reg;
      outData  = mem_reg[rd_reg[AW-1:0]];
   end
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         wr_reg <= '0;
         rd_reg <= '0;
      end else begin
         wr_reg <= wr_next;
         rd_reg <= rd_next;
      end
   end
   // storage carries no reset
   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem_reg[wr_reg[AW-1:0]] <= inData;
      end
   end
endmodule

// ****************************************************************
// top level
// ****************************************************************
module jtxsl_top
   import jtxsl_pkg::*;
(
   input  wire logic          clk_sys,
   input  wire logic          nrst,
   input  wire logic          clockHalveSelect,
   input  wire logic          twoLaneMode,
   input  wire logic [1:0]    subclass,
   input  wire logic          sysrefPin,
   input  wire logic          syncReqN,
   input  wire jtxsl_sample_t sampleIn,
   input  wire logic          sampleValid,
   output logic               sampleReady,
   output jtxsl_lane_t        serial_lane_first,
   output jtxsl_lane_t        serial_lane_second,
   output logic               laneValid,
   output logic               lane_alignment_seq
);
   // pipeline delay in clocks; 1x clock drops the half period
   // taken by falling-edge sampling
   function automatic logic [4:0] latCycles(input logic two,
                                            input logic halve);
      logic [4:0] h;
      h = two ? 5'(LAT_P2_HALF) : 5'(LAT_P1_HALF);
      latCycles = halve ? h : 5'(h >> 1);
   endfunction

   logic          syncA_reg, syncB_reg, syncPrev_reg;
   logic          refA_reg, refB_reg, refPrev_reg;
   logic          syncRise, syncFall, refRise, divInit;
   logic          phase_reg, phase_next, strobe;
   logic [4:0]    lmfc_reg, lmfc_next;
   jtxsl_sample_t fifoData;
   logic          fifoValid, popFire;
   jtxsl_sample_t dly_reg [DLY_DEPTH];
   logic [DLY_DEPTH-1:0] dlyV_reg;
   logic [4:0]    tap;
   jtxsl_state_t  st_reg, st_next;
   logic [7:0]    cnt_reg, cnt_next;
   jtxsl_lane_t   laneA_next, laneB_next;
   logic          laneV_next;

   // ************************************************************
   // pin synchronisers and edge detect
   // ************************************************************
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         syncA_reg    <= 1'b1;
         syncB_reg    <= 1'b1;
         syncPrev_reg <= 1'b1;
         refA_reg     <= 1'b0;
         refB_reg     <= 1'b0;
         refPrev_reg  <= 1'b0;
      end else begin
         syncA_reg    <= syncReqN;
         syncB_reg    <= syncA_reg;
         syncPrev_reg <= syncB_reg;
         refA_reg     <= sysrefPin;
         refB_reg     <= refA_reg;
         refPrev_reg  <= refB_reg;
      end
   end
   // divider init on sysref (sc1) or sync (sc2) rise, see [RULE11]
   always_comb begin
      syncRise = syncB_reg && !syncPrev_reg;
      syncFall = !syncB_reg && syncPrev_reg;
      refRise  = refB_reg && !refPrev_reg;
      divInit  = (subclass == 2'h1 && refRise) ||
                 (subclass == 2'h2 && syncRise);
   end

   // ************************************************************
   // sample divider and multiframe counter
   // ************************************************************
   // halved clock: one sample every second edge, see [RULE9] [RULE12]
   always_comb begin
      strobe     = clockHalveSelect ? phase_reg : 1'b1;
      phase_next = divInit ? 1'b0 : !phase_reg;
      lmfc_next  = lmfc_reg;
      if (divInit) begin
         lmfc_next = '0;
      end else if (strobe) begin
         lmfc_next = (lmfc_reg == 5'(FRAMES_PER_MF-1)) ? '0
                                                       : lmfc_reg + 1'b1;
      end
   end
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         phase_reg <= 1'b0;
         lmfc_reg  <= '0;
      end else begin
         phase_reg <= phase_next;
         lmfc_reg  <= lmfc_next;
      end
   end

   // ************************************************************
   // sample buffer and pipeline delay line
   // ************************************************************
   jtxsl_fifo #(
      .WIDTH ($bits(jtxsl_sample_t)),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_sys  (clk_sys),
      .nrst     (nrst),
      .inData   (sampleIn),
      .inValid  (sampleValid),
      .inReady  (sampleReady),
      .outData  (fifoData),
      .outValid (fifoValid),
      .outReady (strobe)
   );
   assign popFire = fifoValid && strobe;
   assign tap     = latCycles(twoLaneMode, clockHalveSelect);
   // fixed-length shift, output picked at mode tap, see [RULE1] [RULE2]
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         dlyV_reg <= '0;
      end else begin
         dlyV_reg <= {dlyV_reg[DLY_DEPTH-2:0], popFire};
      end
   end
   always_ff @(posedge clk_sys) begin
      dly_reg[0] <= fifoData;
      for (int i = 1; i < DLY_DEPTH; i++) begin
         dly_reg[i] <= dly_reg[i-1];
      end
   end

   // ************************************************************
   // sync sequencing
   // ************************************************************
   always_comb begin
      st_next  = st_reg;
      cnt_next = cnt_reg;
      if (syncFall && st_reg != ST_COMMA_WAIT && st_reg != ST_COMMA) begin
         // request again: go back to commas, see [RULE14]
         st_next  = ST_COMMA_WAIT;
         cnt_next = '0;
      end else begin
         case (st_reg)
            ST_COMMA_WAIT: begin
               // see [RULE3]
               if (strobe) begin
                  cnt_next = cnt_reg + 1'b1;
                  if (cnt_reg[3:0] ==
                      (twoLaneMode ? LAT_SC2 : LAT_SC1) - 4'h1) begin
                     st_next = ST_COMMA;
                  end
               end
            end
            ST_COMMA: begin
               if (syncRise) begin
                  st_next = ST_BOUND;
               end
            end
            ST_BOUND: begin
               // frame start (sc0) or multiframe start, see [RULE5] [RULE6]
               if (strobe && (subclass == 2'h0 || lmfc_reg == '0)) begin
                  st_next  = ST_LAS_WAIT;
                  cnt_next = 8'h01;
               end
            end
            ST_LAS_WAIT: begin
               // see [RULE4]
               if (strobe) begin
                  cnt_next = cnt_reg + 1'b1;
                  if (cnt_reg[3:0] ==
                      (twoLaneMode ? LAT_SL2 : LAT_SL1)) begin
                     st_next  = ST_LAS;
                     cnt_next = '0;
                  end
               end
            end
            ST_LAS: begin
               if (strobe) begin
                  cnt_next = cnt_reg + 1'b1;
                  if (cnt_reg == 8'(LAS_MF*FRAMES_PER_MF-1)) begin
                     st_next = ST_DATA;
                  end
               end
            end
            default: begin
               st_next = ST_DATA;
            end
         endcase
      end
   end
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         st_reg  <= ST_COMMA_WAIT;
         cnt_reg <= '0;
      end else begin
         st_reg  <= st_next;
         cnt_reg <= cnt_next;
      end
   end

   // ************************************************************
   // lane mapping and output registers
   // ************************************************************
   always_comb begin
      jtxsl_sample_t s;
      logic [7:0]    k;
      s          = dly_reg[tap];
      k          = (cnt_reg[4:0] == 5'h1F) ? K28_3 : K28_0;
      laneV_next = 1'b0;
      laneA_next = '0;
      laneB_next = '0;
      if (st_reg == ST_COMMA) begin
         // commas while sync held low, see [RULE10]
         laneV_next = strobe;
         laneA_next = '{1'b1, {4{K28_5}}};
         laneB_next = twoLaneMode ? '{1'b1, {4{K28_5}}} : '0;
      end else if (st_reg == ST_LAS) begin
         laneV_next = strobe;
         laneA_next = '{1'b1, {k, 16'h0, cnt_reg}};
         laneB_next = twoLaneMode ? laneA_next : '0;
      end else if (st_reg == ST_DATA) begin
         // both channels on first lane in one-lane mode, see [RULE13]
         laneV_next = dlyV_reg[tap];
         laneA_next = twoLaneMode ? '{1'b0, {18'h0, s.chanA}}
                                  : '{1'b0, {2'h0, s.chanA, 2'h0, s.chanB}};
         laneB_next = twoLaneMode ? '{1'b0, {18'h0, s.chanB}} : '0;
      end
   end
   // registered lanes: one clock edge to output, see [RULE7] [RULE8]
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         serial_lane_first  <= '0;
         serial_lane_second <= '0;
         laneValid          <= 1'b0;
         lane_alignment_seq <= 1'b0;
      end else begin
         serial_lane_first  <= laneA_next;
         serial_lane_second <= laneB_next;
         laneValid          <= laneV_next;
         lane_alignment_seq <= st_reg == ST_LAS;
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   sequence seqInit;
      divInit;
   endsequence
   sequence seqDivCleared;
      ##1 (lmfc_reg == '0 && !phase_reg);
   endsequence
   AST_DIV_RESET: assert property (seqInit |-> seqDivCleared) // see [RULE11]
      else $error("divider not reset by init event");
   AST_HALVE: assert property (clockHalveSelect && $past(clockHalveSelect)
      && strobe |=> !strobe) // see [RULE12]
      else $error("halved clock sampled two edges running");
   // tap k of the valid line holds the pop of k+1 edges ago
   AST_PIPE1: assert property (st_reg == ST_DATA && !twoLaneMode &&
      !clockHalveSelect |-> laneV_next == $past(popFire, 11)) // see [RULE1]
      else $error("one lane pipeline latency wrong");
   AST_PIPE2: assert property (st_reg == ST_DATA && twoLaneMode &&
      clockHalveSelect |-> laneV_next == $past(popFire, 28)) // see [RULE2]
      else $error("two lane pipeline latency wrong");
   // one edge to enter comma-wait, then 7 strobes there
   AST_COMMA_LAT: assert property (!clockHalveSelect && !twoLaneMode &&
      st_reg == ST_DATA && syncFall |-> ##8 st_reg == ST_COMMA) // see [RULE3]
      else $error("comma latency wrong");
   AST_COMMA_HOLD: assert property (st_reg == ST_COMMA && !syncB_reg
      |=> serial_lane_first.word[7:0] == K28_5) // see [RULE10]
      else $error("comma not held while sync low");
   // one edge out of bound, then 6 strobes of wait
   AST_LAS_LAT: assert property (!clockHalveSelect && twoLaneMode && // see [RULE4]
      st_reg == ST_BOUND && st_next == ST_LAS_WAIT |-> ##7 st_reg == ST_LAS)
      else $error("alignment latency wrong");
   AST_MF_BOUND: assert property (subclass != 2'h0 && st_reg == ST_BOUND
      && st_next == ST_LAS_WAIT |-> lmfc_reg == '0) // see [RULE6]
      else $error("alignment count not from multiframe start");
   AST_DATA_AFTER: assert property (st_reg == ST_LAS && st_next == ST_DATA
      && !syncFall |=> ##1 !lane_alignment_seq) // see [RULE14]
      else $error("data not resumed after alignment");
endmodule
`default_nettype wire

// ---- verification/jtxsl_rx_model.sv ----
// receiver model: drives the sync request toward the transmit block
`timescale 1ns/100ps
`default_nettype none

// ************************************************************
// sync request driver
// ************************************************************
module jtxsl_rx_model (
   input  wire logic       clk_sys,
   input  wire logic       nrst,
   input  wire logic       wantSync,
   input  wire logic [3:0] holdExtra,
   output logic            syncReqN
);
   logic [3:0] holdCnt;

   // request drops at once, release waits out the extra hold (slow rx)
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         syncReqN <= 1'h0;
         holdCnt  <= 4'h0;
      end else if (wantSync) begin
         syncReqN <= 1'h0;
         holdCnt  <= holdExtra;
      end else if (holdCnt != 4'h0) begin
         holdCnt <= holdCnt - 4'h1;
      end else begin
         syncReqN <= 1'h1;
      end
   end
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
// self-checking bench for the transmit link timing block
`timescale 1ns/100ps
`default_nettype none

module testbench
   import jtxsl_pkg::*;
;
   logic          clk_sys, nrst, clockHalveSelect, twoLaneMode, sysrefPin;
   logic [1:0]    subclass;
   logic          sampleValid, sampleReady, laneValid, lane_alignment_seq;
   logic          wantSync, syncReqN;
   logic [3:0]    holdExtra;
   jtxsl_sample_t sampleIn;
   jtxsl_lane_t   laneA, laneB;
   int            n_mismatch, checks_done, cycles;

   jtxsl_top dut (
      .clk_sys(clk_sys), .nrst(nrst), .clockHalveSelect(clockHalveSelect),
      .twoLaneMode(twoLaneMode), .subclass(subclass),
      .sysrefPin(sysrefPin), .syncReqN(syncReqN), .sampleIn(sampleIn),
      .sampleValid(sampleValid), .sampleReady(sampleReady),
      .serial_lane_first(laneA), .serial_lane_second(laneB),
      .laneValid(laneValid), .lane_alignment_seq(lane_alignment_seq));

   jtxsl_rx_model rx (
      .clk_sys(clk_sys), .nrst(nrst), .wantSync(wantSync),
      .holdExtra(holdExtra), .syncReqN(syncReqN));

   // ************************************************************
   // clock, timeout and reporting
   // ************************************************************
   initial begin
      clk_sys = 1'h0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   // cut a hang short
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         summarize();
      end
   end

   task automatic summarize();
      $display("mismatches %0d, checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [63:0] seen, input logic [63:0] exp,
                      input string what);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: %s got %0h want %0h", $time, what,
                  seen, exp);
      end
   endtask

   // ************************************************************
   // scenarios
   // ************************************************************
   // reset with a new configuration, receiver requesting commas
   task automatic start(input logic halve, input logic two,
                        input logic [1:0] sc);
      @(posedge clk_sys);
      nrst <= 1'h0;
      clockHalveSelect <= halve;
      twoLaneMode <= two;
      subclass <= sc;
      wantSync <= 1'h1;
      repeat (8) @(posedge clk_sys);
      nrst <= 1'h1;
      repeat (20) @(posedge clk_sys);
   endtask

   // release sync, time the alignment sequence and the data after it
   task automatic release_sync();
      int n;
      int len;
      logic [3:0] lat;
      lat = twoLaneMode ? LAT_SL2 : LAT_SL1;
      @(posedge clk_sys);
      wantSync <= 1'h0;
      @(posedge syncReqN);
      n = 0;
      do begin @(posedge clk_sys); #1; n++; end
      while (!lane_alignment_seq && n < 300);
      if (clockHalveSelect) chk(lane_alignment_seq, 1'h1, "las");
      else if (subclass == 2'h0) chk(n, 5 + lat, "las lat");
      else chk(n >= 5 + lat && n <= 36 + lat, 1'h1, "las mf");
      chk(laneA.word[31:24], K28_0, "las first byte");
      len = 0;
      while (lane_alignment_seq && len < 600) begin
         @(posedge clk_sys);
         #1;
         len++;
      end
      chk(len, LAS_MF * FRAMES_PER_MF * (clockHalveSelect ? 2 : 1),
          "las len");
      chk(laneA.isCtrl, 1'h0, "data after las");
   endtask

   // request commas from the data state and watch them stand
   task automatic request_sync();
      int n;
      @(posedge clk_sys);
      wantSync <= 1'h1;
      @(negedge syncReqN);
      n = 0;
      do begin @(posedge clk_sys); #1; n++; end
      while (!(laneValid && laneA.isCtrl) && n < 300);
      chk(n, 4 + (twoLaneMode ? LAT_SC2 : LAT_SC1), "comma lat");
      repeat (40) begin
         if (laneValid) chk(laneA, {1'h1, {4{K28_5}}}, "comma");
         if (laneValid && twoLaneMode)
            chk(laneB.word, {4{K28_5}}, "c2");
         @(posedge clk_sys);
         #1;
      end
   endtask

   // push one sample into an idle path and time its arrival
   task automatic pipe(input logic [13:0] a, input logic [13:0] b);
      int n;
      logic [32:0] exp;
      exp = twoLaneMode ? {15'h0, 4'h0, a} : {1'h0, 2'h0, a, 2'h0, b};
      @(posedge clk_sys);
      sampleIn <= '{chanA: a, chanB: b};
      sampleValid <= 1'h1;
      @(posedge clk_sys);
      sampleValid <= 1'h0;
      n = 0;
      do begin @(posedge clk_sys); #1; n++; end
      while (!(laneValid && laneA === exp) && n < 100);
      chk(n, (twoLaneMode ? LAT_P2_HALF : LAT_P1_HALF) / 2 + 2,
          "pipe");
      chk(laneB, twoLaneMode ? {15'h0, 4'h0, b} : 33'h0, "lane B");
   endtask

   // halved clock: fifo fills and drains, strobes every second edge
   task automatic fill();
      int pulses;
      logic full;
      logic prev;
      pulses = 0;
      full = 1'h0;
      prev = 1'h0;
      @(posedge clk_sys);
      sampleIn <= '{chanA: 14'h0155, chanB: 14'h02AA};
      sampleValid <= 1'h1;
      // fill the fifo and the pipe first; valid stays high throughout
      repeat (32) begin
         @(posedge clk_sys);
         #1;
         if (!sampleReady) full = 1'h1;
      end
      // steady flow: exactly every second edge carries a word
      repeat (24) begin
         @(posedge clk_sys);
         #1;
         if (laneValid && prev) chk(1'h1, 1'h0, "strobe pair");
         if (laneValid) pulses++;
         prev = laneValid;
      end
      @(posedge clk_sys);
      sampleValid <= 1'h0;
      repeat (16) @(posedge clk_sys);
      #1;
      chk(full, 1'h1, "fifo full");
      chk(sampleReady, 1'h1, "fifo drained");
      chk(pulses, 12, "strobe count");
   endtask

   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      nrst = 1'h0;
      clockHalveSelect = 1'h0;
      twoLaneMode = 1'h0;
      subclass = 2'h0;
      sysrefPin = 1'h0;
      wantSync = 1'h1;
      holdExtra = 4'h0;
      sampleValid = 1'h0;
      sampleIn = '0;
      start(1'h0, 1'h0, 2'h0);
      release_sync();
      pipe(14'h1A5, 14'h2C3);
      request_sync();
      release_sync();
      pipe(14'h3FFF, 14'h0001);
      start(1'h0, 1'h1, 2'h0);
      holdExtra <= 4'h5;
      release_sync();
      pipe(14'h0ABC, 14'h1234);
      request_sync();
      release_sync();
      start(1'h0, 1'h0, 2'h1);
      sysrefPin <= 1'h1;
      repeat (4) @(posedge clk_sys);
      sysrefPin <= 1'h0;
      release_sync();
      start(1'h1, 1'h0, 2'h2);
      release_sync();
      fill();
      summarize();
   end
endmodule
`default_nettype wire
